// ==== rtl/mcbc_pkg.sv ====
// memory card bus control package: constants, access-time table, carriers
// assumes a 20 MHz system clock and a 26-bit system address
package mcbc_pkg;

	// ****************************************************************
	// address map
	// ****************************************************************
	localparam int unsigned ADDR_W       = 26;
	localparam int unsigned CARD_REGION  = 25;  // top address bit selects card half
	localparam int unsigned SLOT_BIT     = 24;  // slot select in two-slot mode
	localparam int unsigned BANK_LSB     = 20;  // low memory banks of 1MB
	localparam int unsigned BANK_W       = 5;   // 32 banks below the card half
	localparam int unsigned NUM_BANKS    = 32;

	// ****************************************************************
	// access timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned T250_NS       = 250;
	localparam int unsigned T200_NS       = 200;
	localparam int unsigned T150_NS       = 150;
	localparam int unsigned T100_NS       = 100;
	localparam logic [3:0]  CYC_250 = 4'((T250_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0]  CYC_200 = 4'((T200_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0]  CYC_150 = 4'((T150_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0]  CYC_100 = 4'((T100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// access-time codes, 0 is the slowest and the reset value
	typedef enum logic [1:0] {
		MCBC_SPEED_250,
		MCBC_SPEED_200,
		MCBC_SPEED_150,
		MCBC_SPEED_100
	} mcbc_speed_t;
	localparam mcbc_speed_t SPEED_RESET = MCBC_SPEED_250;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic               valid;   // one-cycle start strobe
		logic               write;
		logic               hi_byte; // odd byte lane wanted
		logic               lo_byte; // even byte lane wanted
		logic [ADDR_W-1:0]  addr;
		logic [15:0]        wdata;
	} mcbc_req_t;

	typedef struct packed {
		logic               ce_active_high;  // card enable polarity
		logic               rdy_active_high; // ready input polarity
		logic               two_slots;       // drive slot select from bit 24
		logic               attr_space;      // register-select pin level
		logic               gpio_mode;       // no slots fitted: parallel port
		mcbc_speed_t        speed;
	} mcbc_cfg_t;

	typedef struct packed {
		logic [1:0]         detect_n;  // both low means card present
		logic [1:0]         battery;
		logic               ready;
		logic               present;
	} mcbc_status_t;

	localparam logic [15:0] DATA_IDLE = 16'h0000;

endpackage

// ==== rtl/mcbc_top.sv ====
// memory card bus control: decodes card cycles and drives the card pins
// assumes synchronous inputs, one clock, requests only while o_busy is low
// Functional notes
// - outside port mode, every access in the upper half of 64MB runs as a card cycle
// - 26-bit address; bit 25 high marks the card-reserved region
// - per-bank map bits can route any low bank to the card
// - per-bank width bits choose 8-bit or 16-bit card access
// - software-driven pin selects attribute or common card space
// - single slot: address bits 24..0 reach 32MB per space
// - when enabled, second slot select is inverse of bit 24
// - two slots: address bits 23..0 reach 16MB per card
// - card enable and ready polarities are configurable
// - access time is programmable, slowest is the reset default
// - card status inputs are readable by software
// - settings cover 250, 200, 150ns; 100ns for static RAM only
// - with no slots, control and data pins form a 16-bit port
`timescale 1ns/100ps
module mcbc_top
	import mcbc_pkg::*;
#(
	parameter int unsigned NBANK = NUM_BANKS
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	input  wire mcbc_req_t             i_req,
	input  wire mcbc_cfg_t             i_cfg,
	input  wire logic [NBANK-1:0]      i_bank_to_card,
	input  wire logic [NBANK-1:0]      i_bank_wide,
	input  wire logic                  i_card_ready_in,
	input  wire logic [1:0]            i_card_detect_pair,
	input  wire logic [1:0]            i_card_battery,
	input  wire logic [15:0]           i_data,
	input  wire logic [15:0]           i_gpio_out,
	input  wire logic [15:0]           i_gpio_dir_n,
	output logic [ADDR_W-2:0]          o_card_addr,
	output logic                       o_card_enable_low_byte,
	output logic                       o_card_enable_high_byte,
	output logic                       o_card_output_enable_n,
	output logic                       o_card_write_enable_n,
	output logic                       o_second_slot_select,
	output logic                       o_programmable_pin_two,
	output logic [15:0]                o_data,
	output logic [15:0]                o_data_oe_n,
	output logic                       o_busy,
	output logic                       o_done,
	output logic [15:0]                o_rdata,
	output logic                       o_card_cycle,
	output mcbc_status_t               o_status,
	output logic [15:0]                o_gpio_in
);

	initial begin
		if (NBANK != NUM_BANKS)
			$error("bank count must cover the lower 32MB in 1MB banks");
		if (NBANK != (1 << BANK_W))
			$error("bank index width must match the bank count");
		if (CARD_REGION != ADDR_W - 1)
			$error("card region flag must be the top address bit");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************

	// cycles for an access-time code
	function automatic logic [3:0] speed_cycles(input mcbc_speed_t s);
		logic [3:0] c;
		c = CYC_250;
		unique case (s)
			MCBC_SPEED_250: c = CYC_250;
			MCBC_SPEED_200: c = CYC_200;
			MCBC_SPEED_150: c = CYC_150;
			MCBC_SPEED_100: c = CYC_100;
		endcase
		return c;
	endfunction

	// apply configured polarity to an active-true level
	function automatic logic pol(input logic active, input logic high_true);
		return high_true ? active : ~active;
	endfunction

	// ****************************************************************
	// decode
	// ****************************************************************
	logic [BANK_W-1:0] bank;
	logic              hit_upper;
	logic              hit_bank;
	logic              hit;
	logic              wide;
	logic              ready_true;

	// card region outside port mode: top half always, low banks when mapped
	always_comb begin
		bank       = i_req.addr[BANK_LSB +: BANK_W];
		hit_upper  = i_req.addr[CARD_REGION];
		hit_bank   = i_bank_to_card[bank];
		hit        = ~i_cfg.gpio_mode & (hit_upper | hit_bank);
		wide       = i_bank_wide[bank];
		ready_true = pol(i_card_ready_in, i_cfg.rdy_active_high);
	end

	// ****************************************************************
	// cycle sequencer
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STROBE,
		ST_WAIT_RDY
	} mcbc_state_t;

	mcbc_state_t       state;
	mcbc_state_t       next_state;
	logic [3:0]        count;
	logic [3:0]        next_count;
	logic              cyc_write;
	logic              next_cyc_write;
	logic              ce_lo;
	logic              next_ce_lo;
	logic              ce_hi;
	logic              next_ce_hi;
	logic [ADDR_W-2:0] addr;
	logic [ADDR_W-2:0] next_addr;
	logic [15:0]       wdata;
	logic [15:0]       next_wdata;
	logic              done;
	logic              next_done;
	logic [15:0]       rdata;
	logic [15:0]       next_rdata;

	// latch request, hold strobes for the programmed time, then await ready
	always_comb begin
		next_state     = state;
		next_count     = count;
		next_cyc_write = cyc_write;
		next_ce_lo     = ce_lo;
		next_ce_hi     = ce_hi;
		next_addr      = addr;
		next_wdata     = wdata;
		next_done      = 1'b0;
		next_rdata     = rdata;
		unique case (state)
			ST_IDLE: begin
				next_ce_lo = 1'b0;
				next_ce_hi = 1'b0;
				if (i_req.valid && hit) begin
					next_state     = ST_STROBE;
					next_count     = speed_cycles(i_cfg.speed);
					next_cyc_write = i_req.write;
					// single slot passes 24..0, two slots keep 23..0 per card
					next_addr      = i_req.addr[ADDR_W-2:0];
					if (i_cfg.two_slots)
						next_addr[SLOT_BIT] = 1'b0;
					next_wdata     = i_req.wdata;
					// narrow banks use even enable only, both bytes on the low lane
					next_ce_lo     = wide ? i_req.lo_byte : 1'b1;
					next_ce_hi     = wide & i_req.hi_byte;
				end
			end
			ST_STROBE: begin
				if (count <= 4'h1)
					next_state = ST_WAIT_RDY;
				else
					next_count = count - 4'h1;
			end
			ST_WAIT_RDY: begin
				if (ready_true) begin
					next_state = ST_IDLE;
					next_ce_lo = 1'b0;
					next_ce_hi = 1'b0;
					next_done  = 1'b1;
					if (!cyc_write)
						next_rdata = i_data;
				end
			end
			default: next_state = ST_IDLE;                       // unused code returns to idle
		endcase
	end

	// sequencer registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state     <= ST_IDLE;
			count     <= 4'h0;
			cyc_write <= 1'b0;
			ce_lo     <= 1'b0;
			ce_hi     <= 1'b0;
			addr      <= '0;
			wdata     <= DATA_IDLE;
			done      <= 1'b0;
			rdata     <= DATA_IDLE;
		end else begin
			state     <= next_state;
			count     <= next_count;
			cyc_write <= next_cyc_write;
			ce_lo     <= next_ce_lo;
			ce_hi     <= next_ce_hi;
			addr      <= next_addr;
			wdata     <= next_wdata;
			done      <= next_done;
			rdata     <= next_rdata;
		end
	end

	// ****************************************************************
	// second slot tracking
	// ****************************************************************
	// slot bit kept separately, since the driven address clears it
	logic slot_bit;
	logic next_slot_bit;

	// remember bit 24 of the taken request for the slot select pin
	always_comb begin
		next_slot_bit = slot_bit;
		if (state == ST_IDLE && i_req.valid && hit)
			next_slot_bit = i_req.addr[SLOT_BIT];
	end

	// ****************************************************************
	// pin drivers
	// ****************************************************************
	logic [ADDR_W-2:0]  next_o_addr;
	logic               next_o_ce_lo;
	logic               next_o_ce_hi;
	logic               next_o_oe_n;
	logic               next_o_we_n;
	logic               next_o_slot;
	logic               next_o_pin2;
	logic [15:0]        next_o_data;
	logic [15:0]        next_o_data_oe_n;
	mcbc_status_t       next_o_status;
	logic               act;

	// registered pins; port mode hands pins to software
	always_comb begin
		act              = (next_state != ST_IDLE);
		next_o_addr      = next_addr;
		next_o_ce_lo     = pol(next_ce_lo & act, i_cfg.ce_active_high);
		next_o_ce_hi     = pol(next_ce_hi & act, i_cfg.ce_active_high);
		next_o_oe_n      = ~(act & ~next_cyc_write);
		next_o_we_n      = ~(act & next_cyc_write);
		next_o_slot      = i_cfg.two_slots & ~next_slot_bit;
		next_o_pin2      = i_cfg.attr_space;
		next_o_data      = next_wdata;
		next_o_data_oe_n = {16{~(act & next_cyc_write)}};
		if (i_cfg.gpio_mode) begin
			next_o_data      = i_gpio_out;
			next_o_data_oe_n = i_gpio_dir_n;
			next_o_ce_lo     = i_gpio_out[0];
			next_o_ce_hi     = i_gpio_out[1];
			next_o_oe_n      = i_gpio_out[2];
			next_o_we_n      = i_gpio_out[3];
		end
		next_o_status.detect_n = i_card_detect_pair;
		next_o_status.battery  = i_card_battery;
		next_o_status.ready    = ready_true;
		next_o_status.present  = (i_card_detect_pair == 2'b00);
	end

	// pin and slot registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			slot_bit                <= 1'b0;
			o_card_addr             <= '0;
			o_card_enable_low_byte  <= 1'b0;
			o_card_enable_high_byte <= 1'b0;
			o_card_output_enable_n  <= 1'b1;
			o_card_write_enable_n   <= 1'b1;
			o_second_slot_select    <= 1'b0;
			o_programmable_pin_two  <= 1'b0;
			o_data                  <= DATA_IDLE;
			o_data_oe_n             <= 16'hFFFF;
			o_busy                  <= 1'b0;
			o_done                  <= 1'b0;
			o_rdata                 <= DATA_IDLE;
			o_card_cycle            <= 1'b0;
			o_status                <= '0;
			o_gpio_in               <= DATA_IDLE;
		end else begin
			slot_bit                <= next_slot_bit;
			o_card_addr             <= next_o_addr;
			o_card_enable_low_byte  <= next_o_ce_lo;
			o_card_enable_high_byte <= next_o_ce_hi;
			o_card_output_enable_n  <= next_o_oe_n;
			o_card_write_enable_n   <= next_o_we_n;
			o_second_slot_select    <= next_o_slot;
			o_programmable_pin_two  <= next_o_pin2;
			o_data                  <= next_o_data;
			o_data_oe_n             <= next_o_data_oe_n;
			o_busy                  <= act;
			o_done                  <= next_done;
			o_rdata                 <= next_rdata;
			o_card_cycle            <= act;
			o_status                <= next_o_status;
			o_gpio_in               <= i_data;
		end
	end

endmodule

// ==== verification/mcbc_card_model.sv ====
// card slot model: byte memory, ready delay, detect pins
// assumes the bench joins its data output onto the shared data lines
`timescale 1ns/100ps
module mcbc_card_model (
	input wire logic		i_clk,
	input wire logic		i_ce_lo,
	input wire logic		i_ce_hi,
	input wire logic		i_oe_n,
	input wire logic		i_we_n,
	input wire logic [24:0]		i_addr,
	input wire logic [15:0]		i_bus,
	input wire logic		i_ce_high,
	input wire logic		i_rdy_high,
	input wire logic [3:0]		i_wait,
	input wire logic		i_inserted,
	output logic [15:0]		o_q,
	output logic			o_ready,
	output logic [1:0]		o_detect_n
);
	// ****
	// card behaviour
	// ****
	logic [7:0]	mem [32];
	logic		lo;
	logic		hi;
	logic [3:0]	cnt = 4'h0;
	logic [15:0]	last = 16'h0000;

	// enables and ready follow the set polarity
	assign lo = i_ce_lo == i_ce_high;
	assign hi = i_ce_hi == i_ce_high;
	assign o_ready = ((cnt >= i_wait) || !(lo || hi)) == i_rdy_high;
	assign o_detect_n = i_inserted ? 2'h0 : 2'h3;
	// addressed byte on the low lane when only the low enable is on; else lines toggle
	assign o_q = (lo || hi) && !i_oe_n ? {mem[{i_addr[4:1], 1'b1}], mem[hi ? {i_addr[4:1], 1'b0} : i_addr[4:0]]} : ~last;

	// busy count and byte writes
	always_ff @(posedge i_clk) begin
		last <= o_q;
		cnt <= (lo || hi) ? cnt + 4'(cnt != 4'hf) : 4'h0;
		if (lo && !i_we_n)
			mem[hi ? {i_addr[4:1], 1'b0} : i_addr[4:0]] <= i_bus[7:0];
		if (hi && !i_we_n)
			mem[{i_addr[4:1], 1'b1}] <= i_bus[15:8];
	end
endmodule

// ==== verification/mcbc_properties.sv ====
// checker: port-level properties of the card bus block
// bound into mcbc_top at the foot of this file; reads its ports only
`timescale 1ns/100ps
module mcbc_properties
	import mcbc_pkg::*;
#(
	parameter int unsigned NBANK = NUM_BANKS
) (
	input wire logic		i_clk,
	input wire logic		i_arst_n,
	input wire mcbc_req_t		i_req,
	input wire mcbc_cfg_t		i_cfg,
	input wire logic [NBANK-1:0]	i_bank_to_card,
	input wire logic [NBANK-1:0]	i_bank_wide,
	input wire logic [1:0]		i_card_detect_pair,
	input wire logic [ADDR_W-2:0]	o_card_addr,
	input wire logic		o_card_enable_low_byte,
	input wire logic		o_card_enable_high_byte,
	input wire logic		o_second_slot_select,
	input wire logic		o_busy,
	input wire logic		o_done,
	input wire logic		o_card_cycle,
	input wire mcbc_status_t	o_status
);
	// ****
	// request capture and properties
	// ****
	logic			hit;
	logic			take;
	logic			off;
	logic [ADDR_W-1:0]	cap;
	logic [ADDR_W-1:0]	next_cap;
	logic [3:0]		cnt;
	logic [3:0]		next_cnt;

	// request hits the card half or a mapped bank
	assign hit = i_req.addr[CARD_REGION] | i_bank_to_card[i_req.addr[SLOT_BIT:BANK_LSB]];
	assign take = i_req.valid & ~o_busy & hit & ~i_cfg.gpio_mode;
	assign off = ~i_cfg.ce_active_high;	// inactive enable level

	// taken address and cycles since the take
	always_comb begin
		next_cap = take ? i_req.addr : cap;
		next_cnt = take ? 4'h1 : cnt + 4'(cnt != 4'hf);
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cap <= '0;
			cnt <= 4'hf;
		end else begin
			cap <= next_cap;
			cnt <= next_cnt;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_start;
		o_busy && o_card_cycle;
	endsequence
	sequence s_idle;
		!o_busy && !i_cfg.gpio_mode;
	endsequence

	card_region_a: assert property (take && i_req.addr[CARD_REGION] |=> s_start)
		else $error("card cycle not started");
	bank_map_a: assert property (
		i_req.valid && !o_busy && !i_cfg.gpio_mode && !i_req.addr[CARD_REGION] |=> o_busy == $past(hit))
		else $error("bank map not followed");
	narrow_bank_a: assert property (
		o_busy && !cap[CARD_REGION] && !i_bank_wide[cap[SLOT_BIT:BANK_LSB]] |-> o_card_enable_high_byte == off)
		else $error("high enable on narrow bank");
	card_addr_a: assert property (
		o_busy |-> o_card_addr == {cap[SLOT_BIT] & ~i_cfg.two_slots, cap[23:0]})
		else $error("card address wrong");
	slot_select_a: assert property (o_busy && i_cfg.two_slots |-> o_second_slot_select == !cap[SLOT_BIT])
		else $error("slot select wrong");
	idle_enable_a: assert property (
		s_idle ##1 s_idle |-> !$stable(i_cfg) || {o_card_enable_low_byte, o_card_enable_high_byte} == {2{off}})
		else $error("enable active while idle");
	access_time_a: assert property ($rose(o_done) |-> cnt >= 4'h7 - 4'(i_cfg.speed))
		else $error("access shorter than set");
	status_pins_a: assert property (
		$past(i_arst_n) |-> o_status.detect_n == $past(i_card_detect_pair)
		&& o_status.present == ($past(i_card_detect_pair) == 2'h0))
		else $error("status lines wrong");
endmodule

bind mcbc_top mcbc_properties #(.NBANK(NBANK)) u_props (
	.i_clk, .i_arst_n, .i_req, .i_cfg, .i_bank_to_card, .i_bank_wide,
	.i_card_detect_pair, .o_card_addr, .o_card_enable_low_byte,
	.o_card_enable_high_byte, .o_second_slot_select, .o_busy, .o_done,
	.o_card_cycle, .o_status
);

// ==== verification/test_memory_card_bus_control.sv ====
// testbench: card bus block with one card slot model
// card model and block share the data lines; one task per scenario
`timescale 1ns/100ps
module test_memory_card_bus_control import mcbc_pkg::*;;
	logic		i_clk = 1'b0;
	logic		i_arst_n = 1'b0;
	mcbc_req_t	i_req = '0;
	mcbc_cfg_t	i_cfg = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, MCBC_SPEED_250};
	logic [31:0]	i_bank_to_card = '0, i_bank_wide = '1;
	logic [15:0]	i_gpio_out = '0, i_gpio_dir_n = 16'hffff, q, i_data;
	logic [1:0]	i_card_battery = 2'h2, i_card_detect_pair;
	logic		ins = 1'b1, i_card_ready_in;
	logic [3:0]	wt = 4'h0;
	logic [24:0]	o_card_addr;
	logic [15:0]	o_data, o_data_oe_n, o_rdata, o_gpio_in;
	logic		o_card_enable_low_byte, o_card_enable_high_byte, o_card_output_enable_n;
	logic		o_card_write_enable_n, o_second_slot_select, o_programmable_pin_two, o_busy, o_done;
	mcbc_status_t	o_status;
	logic		o_card_cycle, ce_lo_q, ce_hi_q;
	int		err_count = 0, checked = 0, n;

	// data lines: block where it drives, card elsewhere
	assign i_data = (o_data & ~o_data_oe_n) | (q & o_data_oe_n);
	// card enables qualified by the cycle marker, as a bank select or bit 25 gate would do
	assign ce_lo_q = o_card_cycle ? o_card_enable_low_byte : ~i_cfg.ce_active_high;
	assign ce_hi_q = o_card_cycle ? o_card_enable_high_byte : ~i_cfg.ce_active_high;
	mcbc_top DUT (
		.i_clk, .i_arst_n, .i_req, .i_cfg, .i_bank_to_card, .i_bank_wide, .i_card_ready_in,
		.i_card_detect_pair, .i_card_battery, .i_data, .i_gpio_out, .i_gpio_dir_n, .o_card_addr,
		.o_card_enable_low_byte, .o_card_enable_high_byte, .o_card_output_enable_n, .o_card_write_enable_n,
		.o_second_slot_select, .o_programmable_pin_two, .o_data, .o_data_oe_n, .o_busy, .o_done,
		.o_rdata, .o_card_cycle, .o_status, .o_gpio_in
	);
	mcbc_card_model card (
		.i_clk, .i_ce_lo(ce_lo_q), .i_ce_hi(ce_hi_q),
		.i_oe_n(o_card_output_enable_n), .i_we_n(o_card_write_enable_n), .i_addr(o_card_addr),
		.i_bus(i_data), .i_ce_high(i_cfg.ce_active_high), .i_rdy_high(i_cfg.rdy_active_high), .i_wait(wt),
		.i_inserted(ins), .o_q(q), .o_ready(i_card_ready_in), .o_detect_n(i_card_detect_pair)
	);

	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one access; n counts clocks from take to done, 60 if none
	task automatic acc(input logic [25:0] a, input logic w, input logic [1:0] ln, input logic [15:0] d);
		@(posedge i_clk);
		i_req <= '{1'b1, w, ln[1], ln[0], a, d};
		@(posedge i_clk);
		i_req.valid <= 1'b0;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (o_done !== 1'b1 && n < 60);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_stat;
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			ins <= k[0];
			i_card_battery <= 2'(k + 1);
			i_cfg.attr_space <= k[0];
			@(posedge i_clk);
			@(negedge i_clk);
			chk(o_status, {k[0] ? 2'h0 : 2'h3, 2'(k + 1), 1'b1, k[0]});
			chk(o_programmable_pin_two, k[0]);
		end
		$display("test status done");
	endtask
	task automatic t_port;
		@(posedge i_clk);
		i_cfg.gpio_mode <= 1'b1;
		i_gpio_out <= 16'h5a3c;
		i_gpio_dir_n <= 16'h0000;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk({o_data, o_gpio_in}, {16'h5a3c, 16'h5a3c});
		chk({o_card_write_enable_n, o_card_output_enable_n, o_card_enable_high_byte, o_card_enable_low_byte}, 4'hc);
		@(posedge i_clk);
		i_cfg.gpio_mode <= 1'b0;
		i_gpio_dir_n <= 16'hffff;
		$display("test port done");
	endtask
	task automatic t_high;
		for (int s = 0; s < 4; s++) begin
			@(posedge i_clk);
			i_cfg.speed <= mcbc_speed_t'(s);
			acc(26'h200_0010 + 26'(2 * s), 1'b1, 2'h3, 16'hc3a0 | 16'(s));
			chk(n, 7 - s);
			acc(26'h200_0010 + 26'(2 * s), 1'b0, 2'h3, 16'h0000);
			chk(o_rdata, 16'hc3a0 | 16'(s));
		end
		$display("test high done");
	endtask
	task automatic t_bank;
		@(posedge i_clk);
		i_bank_to_card <= 32'h0000_0048;
		i_bank_wide <= 32'h0000_0040;
		acc(26'h030_0005, 1'b1, 2'h1, 16'h005a);
		acc(26'h030_0005, 1'b0, 2'h1, 16'h0000);
		chk(o_rdata[7:0], 8'h5a);
		acc(26'h060_0008, 1'b1, 2'h3, 16'hbe5a);
		acc(26'h060_0008, 1'b0, 2'h3, 16'h0000);
		chk(o_rdata, 16'hbe5a);
		acc(26'h040_0000, 1'b1, 2'h3, 16'h1234);
		chk(n, 60);
		$display("test bank done");
	endtask
	task automatic t_two;
		@(posedge i_clk);
		i_cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, MCBC_SPEED_100};
		wt <= 4'h6;
		i_bank_wide <= '1;
		for (int b = 0; b < 2; b++) begin
			acc({1'b1, b[0], 24'h00_0020}, 1'b1, 2'h3, 16'h6c00 | 16'(b));
			chk(n > 4, 1'b1);
		end
		acc(26'h200_0020, 1'b0, 2'h3, 16'h0000);
		chk(o_rdata, 16'h6c01);
		$display("test two slots done");
	endtask

	initial begin
		forever #25 i_clk = ~i_clk;
	end
	// watchdog well past the expected run
	initial begin
		#100_000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_arst_n <= 1'b1;
		t_stat();
		t_port();
		t_high();
		t_bank();
		t_two();
		finish_test();
	end
endmodule
